// >>> logic/idiop_pkg.sv
// constants, field positions and carrier types for the discrete i/o port block
// assumes a 50 MHz aclk and an AXI4-Lite master with 32-bit data
// Summary of operation
// RULE_01 - internal input port bit 0 reads 1 when bench sync good, 0 on error.
// RULE_02 - internal output port shares index 322 hex; bits 2 to 5 are spares.
// RULE_03 - internal output bit 0 set to 1 turns electrical self-test on, 0 off.
// RULE_04 - internal output bit 1 set to 1 enables dark calibration, 0 disables.
// RULE_05 - internal output bit 6 at 1 holds the I2C peripherals in reset.
// RULE_06 - internal output bit 7 is active-low reset of the I2C bus controller.
// RULE_07 - control input port A carries remote inputs on bits 0-2; bits 6-7 read 1.
// RULE_08 - remote party drives zero request low to enter zero cal, high to leave.
// RULE_09 - remote party drives span request low to enter span cal, high to leave.
// RULE_10 - remote party holds range select low for high range, high for low range.
// RULE_11 - control input port B bits 0-5 are unused; bits 6 and 7 read 1.
// RULE_12 - control output port A provides eight spare output bits.
// RULE_13 - control output port B provides four spare output bits 0 to 3.
// RULE_14 - remote contact inputs pass a two-flop synchroniser before being read.
package idiop_pkg;
  localparam int unsigned AXI_AW = 12;
  localparam int unsigned IDX_W = 10;
  localparam logic [IDX_W-1:0] IDX_CTRL_A = 10'h321;
  localparam logic [IDX_W-1:0] IDX_INTERNAL = 10'h322;
  localparam logic [IDX_W-1:0] IDX_CTRL_B = 10'h325;
  localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 10'h340;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 10'h341;
  localparam logic [IDX_W-1:0] IDX_OUT_READBACK = 10'h342;

  localparam int unsigned BIT_SELFTEST = 0;
  localparam int unsigned BIT_DARK_CAL = 1;
  localparam int unsigned BIT_SPARE_LO = 2;
  localparam int unsigned BIT_SPARE_HI = 5;
  localparam int unsigned BIT_PERIPH_RST = 6;
  localparam int unsigned BIT_CTRL_RST_N = 7;

  localparam logic [7:0] INTERNAL_OUT_RST = 8'h80;
  localparam logic [7:0] CTRL_A_OUT_RST = 8'h00;
  localparam logic [3:0] CTRL_B_OUT_RST = 4'h0;
  localparam logic [7:0] CTRL_IN_ONES = 8'hC0;

  localparam int unsigned NUM_EV = 4;
  localparam int unsigned EV_SYNC_LOST = 0;
  localparam int unsigned EV_ZERO_REQ = 1;
  localparam int unsigned EV_SPAN_REQ = 2;
  localparam int unsigned EV_RANGE_CHG = 3;
  localparam logic [NUM_EV-1:0] IRQ_MASK_RST = 4'h0;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic range_n;
    logic span_n;
    logic zero_n;
    logic sync_ok;
  } idiop_pins_t;

  localparam idiop_pins_t PINS_IDLE = 4'hF;
endpackage

// >>> logic/idiop_ports.sv
// discrete i/o ports: internal bench port, two control ports, event interrupt
// assumes an AXI4-Lite master on aclk; pin inputs are asynchronous to aclk
`timescale 1ns/1ps
module idiop_ports
  import idiop_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic bench_sync_ok,
  input wire logic remote_zero_request_n,
  input wire logic remote_span_request_n,
  input wire logic remote_upper_range_sel_n,
  output logic electrical_selftest_on,
  output logic dark_cal_enable,
  output logic [3:0] internal_spare_out,
  output logic i2c_periph_reset,
  output logic bus_controller_hw_reset_n,
  output logic [7:0] ctrl_spare_out_a,
  output logic [3:0] ctrl_spare_out_b,
  output logic irq
);

  idiop_pins_t pins_raw;
  idiop_pins_t sync1_q, sync1_d;
  idiop_pins_t sync2_q, sync2_d;
  idiop_pins_t prev_q, prev_d;

  logic [7:0] internal_out_q, internal_out_d;
  logic [7:0] ctrl_a_out_q, ctrl_a_out_d;
  logic [3:0] ctrl_b_out_q, ctrl_b_out_d;
  logic [NUM_EV-1:0] irq_status_q, irq_status_d;
  logic [NUM_EV-1:0] irq_mask_q, irq_mask_d;
  logic [NUM_EV-1:0] events;

  logic aw_have_q, aw_have_d;
  logic [IDX_W-1:0] aw_idx_q, aw_idx_d;
  logic w_have_q, w_have_d;
  logic [7:0] wdata_q, wdata_d;
  logic wstrb0_q, wstrb0_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;

  logic do_write;
  logic [IDX_W-1:0] ar_idx;
  logic [7:0] rd_byte;
  logic rd_hit;
  logic store;
  logic wr_mapped;
  logic sel_internal;
  logic sel_ctrl_a;
  logic sel_ctrl_b;
  logic sel_irq_mask;
  logic sel_irq_status;
  logic irq_q, irq_d;

  assign pins_raw = '{range_n: remote_upper_range_sel_n, span_n: remote_span_request_n,
                      zero_n: remote_zero_request_n, sync_ok: bench_sync_ok};

  // synchroniser: stage one is read only by stage two
  always_comb begin
    sync1_d = pins_raw; // RULE_14
    sync2_d = sync1_q; // RULE_14
    prev_d = sync2_q;
  end

  // stages start at the idle pin levels so leaving reset makes no false event
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= PINS_IDLE;
      sync2_q <= PINS_IDLE;
      prev_q <= PINS_IDLE;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      prev_q <= prev_d;
    end
  end

  // events: sync lost, zero and span requests entered, range selection changed
  always_comb begin
    events = '0;
    events[EV_SYNC_LOST] = prev_q.sync_ok & ~sync2_q.sync_ok;
    events[EV_ZERO_REQ] = prev_q.zero_n & ~sync2_q.zero_n; // RULE_08
    events[EV_SPAN_REQ] = prev_q.span_n & ~sync2_q.span_n; // RULE_09
    events[EV_RANGE_CHG] = prev_q.range_n ^ sync2_q.range_n; // RULE_10
  end

  // axi write path: address and data taken in either order, then one write
  assign s_axi_awready = ~aw_have_q;
  assign s_axi_wready = ~w_have_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  // a write waits while a response is still pending, so none is overwritten
  assign do_write = aw_have_q & w_have_q & ~bvalid_q;
  // only byte lane 0 carries a port; a cleared strobe still answers okay
  assign store = do_write & wstrb0_q;

  // one select per mapped index; readback is mapped but takes no bits
  always_comb begin
    sel_internal = 1'b0;
    sel_ctrl_a = 1'b0;
    sel_ctrl_b = 1'b0;
    sel_irq_mask = 1'b0;
    sel_irq_status = 1'b0;
    wr_mapped = 1'b1;
    case (aw_idx_q)
      IDX_INTERNAL: sel_internal = 1'b1;
      IDX_CTRL_A: sel_ctrl_a = 1'b1;
      IDX_CTRL_B: sel_ctrl_b = 1'b1;
      IDX_IRQ_MASK: sel_irq_mask = 1'b1;
      IDX_IRQ_STATUS: sel_irq_status = 1'b1;
      IDX_OUT_READBACK: wr_mapped = 1'b1;
      default: wr_mapped = 1'b0;
    endcase
  end

  always_comb begin
    aw_have_d = aw_have_q;
    aw_idx_d = aw_idx_q;
    w_have_d = w_have_q;
    wdata_d = wdata_q;
    wstrb0_d = wstrb0_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    if (s_axi_awvalid && !aw_have_q) begin
      aw_have_d = 1'b1;
      aw_idx_d = s_axi_awaddr[AXI_AW-1:2];
    end
    if (s_axi_wvalid && !w_have_q) begin
      w_have_d = 1'b1;
      wdata_d = s_axi_wdata[7:0];
      wstrb0_d = s_axi_wstrb[0];
    end
    if (do_write) begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      if (wr_mapped) begin
        bresp_d = RESP_OKAY;
      end else begin
        bresp_d = RESP_SLVERR;
      end
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      aw_idx_q <= '0;
      w_have_q <= 1'b0;
      wdata_q <= 8'h00;
      wstrb0_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else begin
      aw_have_q <= aw_have_d;
      aw_idx_q <= aw_idx_d;
      w_have_q <= w_have_d;
      wdata_q <= wdata_d;
      wstrb0_q <= wstrb0_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
    end
  end

  // register file
  always_comb begin
    internal_out_d = internal_out_q;
    ctrl_a_out_d = ctrl_a_out_q;
    ctrl_b_out_d = ctrl_b_out_q;
    irq_mask_d = irq_mask_q;
    irq_status_d = irq_status_q;
    if (store && sel_internal) begin
      internal_out_d = wdata_q; // RULE_02
    end
    if (store && sel_ctrl_a) begin
      ctrl_a_out_d = wdata_q; // RULE_12
    end
    if (store && sel_ctrl_b) begin
      ctrl_b_out_d = wdata_q[3:0]; // RULE_13
    end
    if (store && sel_irq_mask) begin
      irq_mask_d = wdata_q[NUM_EV-1:0];
    end
    if (store && sel_irq_status) begin
      irq_status_d = irq_status_q & ~wdata_q[NUM_EV-1:0];
    end
    // a new event wins over a clear in the same cycle
    irq_status_d = irq_status_d | events;
    // taken from the next values, so irq follows status with no added lag
    irq_d = |(irq_status_d & irq_mask_d);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      internal_out_q <= INTERNAL_OUT_RST;
      ctrl_a_out_q <= CTRL_A_OUT_RST;
      ctrl_b_out_q <= CTRL_B_OUT_RST;
      irq_mask_q <= IRQ_MASK_RST;
      irq_status_q <= '0;
      irq_q <= 1'b0;
    end else begin
      internal_out_q <= internal_out_d;
      ctrl_a_out_q <= ctrl_a_out_d;
      ctrl_b_out_q <= ctrl_b_out_d;
      irq_mask_q <= irq_mask_d;
      irq_status_q <= irq_status_d;
      irq_q <= irq_d;
    end
  end

  assign electrical_selftest_on = internal_out_q[BIT_SELFTEST]; // RULE_03
  assign dark_cal_enable = internal_out_q[BIT_DARK_CAL]; // RULE_04
  assign internal_spare_out = internal_out_q[BIT_SPARE_HI:BIT_SPARE_LO]; // RULE_02
  assign i2c_periph_reset = internal_out_q[BIT_PERIPH_RST]; // RULE_05
  assign bus_controller_hw_reset_n = internal_out_q[BIT_CTRL_RST_N]; // RULE_06
  assign ctrl_spare_out_a = ctrl_a_out_q; // RULE_12
  assign ctrl_spare_out_b = ctrl_b_out_q; // RULE_13
  assign irq = irq_q;

  // axi read path: reads at shared indices return the input port
  assign ar_idx = s_axi_araddr[AXI_AW-1:2];
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  always_comb begin
    rd_hit = 1'b1;
    rd_byte = 8'h00;
    case (ar_idx)
      IDX_INTERNAL: rd_byte = {7'h00, sync2_q.sync_ok}; // RULE_01
      IDX_CTRL_A: rd_byte = CTRL_IN_ONES |
                            {5'h00, sync2_q.range_n, sync2_q.span_n, sync2_q.zero_n}; // RULE_07
      IDX_CTRL_B: rd_byte = CTRL_IN_ONES; // RULE_11
      IDX_IRQ_STATUS: rd_byte = {4'h0, irq_status_q};
      IDX_IRQ_MASK: rd_byte = {4'h0, irq_mask_q};
      IDX_OUT_READBACK: rd_byte = internal_out_q;
      default: rd_hit = 1'b0;
    endcase
  end

  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (s_axi_arvalid && !rvalid_q) begin
      rvalid_d = 1'b1;
      rdata_d = {24'h000000, rd_byte};
      rresp_d = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= RESP_OKAY;
    end else begin
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

endmodule

// >>> dv/idiop_far.sv
// contact-closure and bench-sync sources at the far side of the ports
// assumes the bench sets want just after a rising aclk edge
`timescale 1ns/1ps
module idiop_far
  import idiop_pkg::*;
(
  input wire logic aclk,
  input wire idiop_pins_t want,
  output idiop_pins_t pins
);
  // contacts move one edge after they are asked for, unrelated to reads
  always @(posedge aclk) pins <= want;
endmodule

// >>> dv/idiop_asserts.sv
// checker for the discrete i/o ports, bound to idiop_ports
// assumes one aclk domain with synchronous active-low aresetn
`timescale 1ns/1ps
module idiop_asserts
  import idiop_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic electrical_selftest_on,
  input wire logic dark_cal_enable,
  input wire logic i2c_periph_reset,
  input wire logic bus_controller_hw_reset_n
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  wr_resp_a: assert property (wr_take |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response not two cycles after request");
  rd_resp_a: assert property (ar_take |=> s_axi_rvalid)
    else $error("read data not one cycle after request");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while data pending");
  sync_rd_a: assert property ($rose(s_axi_rvalid) && $past(s_axi_araddr[11:2]) == IDX_INTERNAL
    |-> s_axi_rdata[31:1] == 31'h0)
    else $error("internal input spare bits not zero");
  ctla_rd_a: assert property ($rose(s_axi_rvalid) && $past(s_axi_araddr[11:2]) == IDX_CTRL_A
    |-> s_axi_rdata[31:3] == 29'h18)
    else $error("control input a fixed bits wrong");
  ctlb_rd_a: assert property ($rose(s_axi_rvalid) && $past(s_axi_araddr[11:2]) == IDX_CTRL_B
    |-> s_axi_rdata == 32'h000000C0)
    else $error("control input b wrong");
  out_hold_a: assert property ($past(aresetn) && !$rose(s_axi_bvalid) |-> $stable({electrical_selftest_on,
    dark_cal_enable, i2c_periph_reset, bus_controller_hw_reset_n}))
    else $error("internal outputs moved without a write");
  rst_out_a: assert property ($rose(aresetn) |-> bus_controller_hw_reset_n && !i2c_periph_reset
    && !electrical_selftest_on && !dark_cal_enable)
    else $error("internal outputs not at reset values");
endmodule

bind idiop_ports idiop_asserts i_idiop_asserts (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .electrical_selftest_on, .dark_cal_enable, .i2c_periph_reset,
  .bus_controller_hw_reset_n);

// >>> dv/test_idiop_ports.sv
// self-checking bench for the discrete i/o ports over AXI4-Lite
// assumes idiop_far for the contacts and the bound idiop_asserts checker
`timescale 1ns/1ps
module test_idiop_ports
  import idiop_pkg::*;
;
  localparam logic [11:0] A_CA = {IDX_CTRL_A, 2'b00};
  localparam logic [11:0] A_INT = {IDX_INTERNAL, 2'b00};
  localparam logic [11:0] A_CB = {IDX_CTRL_B, 2'b00};
  localparam logic [11:0] A_ST = {IDX_IRQ_STATUS, 2'b00};
  localparam logic [11:0] A_MSK = {IDX_IRQ_MASK, 2'b00};
  localparam logic [11:0] A_RBK = {IDX_OUT_READBACK, 2'b00};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic [11:0] s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, v;
  logic electrical_selftest_on, dark_cal_enable, i2c_periph_reset, bus_controller_hw_reset_n;
  logic [3:0] internal_spare_out, ctrl_spare_out_b;
  logic [7:0] ctrl_spare_out_a;
  idiop_pins_t want = PINS_IDLE;
  idiop_pins_t pins;
  logic [31:0] seed = 32'h41CBB75F;
  int error_cnt = 0;
  int total_checks = 0;
  int cyc = 0;
  always #10 aclk = ~aclk;
  idiop_far i_idiop_far (.aclk, .want, .pins);
  idiop_ports i_idiop_ports (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .bench_sync_ok(pins.sync_ok), .remote_zero_request_n(pins.zero_n),
    .remote_span_request_n(pins.span_n), .remote_upper_range_sel_n(pins.range_n),
    .electrical_selftest_on, .dark_cal_enable, .internal_spare_out, .i2c_periph_reset,
    .bus_controller_hw_reset_n, .ctrl_spare_out_a, .ctrl_spare_out_b, .irq);
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [31:0] ctla(input idiop_pins_t p);
    return {24'h0, 2'b11, 3'b000, p.range_n, p.span_n, p.zero_n};
  endfunction
  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  // bus handshakes are judged on values sampled half a cycle before the edge
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ta, tw, tb;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = s_axi_awready;
      tw = s_axi_wready;
      tb = s_axi_bvalid;
      chk(s_axi_bresp & {2{tb}}, r & {2{tb}});
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end while (!tb);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ta, tb;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = s_axi_arready;
      tb = s_axi_rvalid;
      if (tb) chk({s_axi_rresp, s_axi_rdata[29:0]}, {r, d[29:0]});
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
    end while (!tb);
    s_axi_rready <= 1'b0;
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      end_sim();
    end
  end
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    chk({electrical_selftest_on, dark_cal_enable, internal_spare_out, i2c_periph_reset,
      bus_controller_hw_reset_n, ctrl_spare_out_a, ctrl_spare_out_b}, 32'h01000);
    for (int i = 0; i < 6; i++) begin
      v = rnd();
      if (i < 2) v = {32{i[0]}};
      wr(A_INT, v, RESP_OKAY);
      chk({bus_controller_hw_reset_n, i2c_periph_reset, internal_spare_out, dark_cal_enable,
        electrical_selftest_on}, v[7:0]);
      rd(A_RBK, {24'h0, v[7:0]}, RESP_OKAY);
      wr(A_CA, v, RESP_OKAY);
      wr(A_CB, v >> 8, RESP_OKAY);
      chk({ctrl_spare_out_a, ctrl_spare_out_b}, {v[7:0], v[11:8]});
    end
    wr(12'hC00, 32'h0, RESP_SLVERR);
    wr(A_RBK, 32'h0, RESP_OKAY);
    rd(A_RBK, {24'h0, v[7:0]}, RESP_OKAY);
    for (int i = 0; i < 8; i++) begin
      v = rnd();
      if (i < 2) v = {32{i[0]}};
      want <= idiop_pins_t'(v[3:0]);
      repeat (4) @(posedge aclk);
      rd(A_CA, ctla(want), RESP_OKAY);
      rd(A_INT, {31'h0, want.sync_ok}, RESP_OKAY);
      rd(A_CB, 32'hC0, RESP_OKAY);
    end
    want <= PINS_IDLE;
    repeat (5) @(posedge aclk);
    wr(A_ST, 32'hF, RESP_OKAY);
    rd(A_ST, 32'h0, RESP_OKAY);
    wr(A_MSK, 32'h2, RESP_OKAY);
    want <= idiop_pins_t'(4'hD);
    repeat (5) @(posedge aclk);
    chk(irq, 32'h1);
    rd(A_ST, 32'h2, RESP_OKAY);
    wr(A_MSK, 32'h0, RESP_OKAY);
    chk(irq, 32'h0);
    wr(A_ST, 32'h2, RESP_OKAY);
    rd(A_ST, 32'h0, RESP_OKAY);
    // sync lost, span entered and range moved together; leaving zero sets nothing
    want <= idiop_pins_t'(4'h2);
    repeat (5) @(posedge aclk);
    rd(A_ST, 32'hD, RESP_OKAY);
    // a reset in mid-run brings every pin output and irq back to its reset value
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    chk({electrical_selftest_on, dark_cal_enable, internal_spare_out, i2c_periph_reset,
      bus_controller_hw_reset_n, ctrl_spare_out_a, ctrl_spare_out_b,
      irq}, 32'h02000);
    end_sim();
  end
endmodule
